// File: hdl/clk_rst_pkg.sv
// Constants for the clock, reset and pad control block
package clk_rst_pkg;
  // Supported crystal references
  localparam int unsigned CRYSTAL_LOW_HZ   = 32768;
  localparam int unsigned CRYSTAL_HIGH_HZ  = 38400;
  // Output frequency with the lower reference
  localparam int unsigned CORE_CLK_HZ      = 16580000;
  localparam int unsigned SYS_CLK_HZ       = 125000000;
  // First prescaler divides the loop clock into the display DMA clock
  localparam int unsigned PRE1_DIV         = SYS_CLK_HZ / CORE_CLK_HZ;
  localparam int unsigned PRE2_DIV         = 1;
  localparam int unsigned DIV_W            = 4;
  localparam logic [DIV_W-1:0] PRE1_LAST   = DIV_W'(PRE1_DIV - 1);
  localparam logic [DIV_W-1:0] PRE2_LAST   = DIV_W'(PRE2_DIV - 1);
  // Least external reset hold time
  localparam real        RESET_HOLD_S      = 1.2;
  localparam longint     RESET_HOLD_CYC    = longint'(RESET_HOLD_S * SYS_CLK_HZ);
  // Pad select encoding
  typedef enum logic {PAD_GPIO, PAD_CLKOUT} pad_sel_t;
  localparam logic       PAD_SEL_RST       = 1'h0;
  localparam logic       CLKOUT_EN_RST     = 1'h1;
  localparam logic [2:0] SYNC_RST          = 3'h0;
endpackage : clk_rst_pkg

// File: hdl/clock_reset_pin_logic.sv
// Clock generation enables, clock output pad and reset pin logic
`timescale 1ns/100ps
`default_nettype none
module clock_reset_pin_logic (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic crystal_input,
  input  wire logic crystal_sel_high,
  output logic      crystal_drive_output,
  output logic      pll_output_clock,
  output logic      core_system_clock,
  output logic      display_dma_clock,
  input  wire logic reset_pin_b,
  input  wire logic cpu_reset_instr,
  output logic      cpu_reset_b,
  output logic      periph_reset_b,
  input  wire logic pad_sel_clkout,
  input  wire logic clkout_enable,
  input  wire logic port_f_bit_two_out,
  input  wire logic port_f_bit_two_oe,
  output logic      port_f_bit_two_in,
  input  wire logic clock_output_pin_i,
  output logic      clock_output_pin_o,
  output logic      clock_output_pin_oe,
  output logic      crystal_is_high
);
  logic [2:0] rst_sync_ff;
  logic [2:0] nxt_rst_sync;
  logic [2:0] pad_sync_ff;
  logic [2:0] nxt_pad_sync;
  logic       rst_level_ff;
  logic       nxt_rst_level;
  logic       sel_ff;
  logic       nxt_sel;
  logic       dis_ff;
  logic       nxt_dis;
  logic       hi_ff;
  logic       nxt_hi;
  logic       clkgen_ff;
  logic       nxt_clkgen;
  logic       pin_o_ff;
  logic       nxt_pin_o;
  logic       pin_oe_ff;
  logic       nxt_pin_oe;
  logic       pin_in_ff;
  logic       nxt_pin_in;
  logic       pll_en;
  logic       dma_en;
  logic       sys_en;

  // Loop enable free-runs; crystal feeds the oscillator only
  assign pll_en = 1'b1;

  prescaler #(.W(clk_rst_pkg::DIV_W)) u_pre1 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en_in   (pll_en),
    .last    (clk_rst_pkg::PRE1_LAST),
    .en_out  (dma_en)
  );
  prescaler #(.W(clk_rst_pkg::DIV_W)) u_pre2 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .en_in   (dma_en),
    .last    (clk_rst_pkg::PRE2_LAST),
    .en_out  (sys_en)
  );

  assign pll_output_clock     = pll_en;
  assign display_dma_clock    = dma_en;
  assign core_system_clock    = sys_en;
  assign crystal_drive_output = ~crystal_input;
  assign crystal_is_high      = hi_ff;
  assign cpu_reset_b          = rst_level_ff;
  assign periph_reset_b       = rst_level_ff;
  assign clock_output_pin_o   = pin_o_ff;
  assign clock_output_pin_oe  = pin_oe_ff;
  assign port_f_bit_two_in    = pin_in_ff;

  always_comb begin
    nxt_rst_sync  = {rst_sync_ff[1:0], reset_pin_b};
    nxt_pad_sync  = {pad_sync_ff[1:0], clock_output_pin_i};
    nxt_rst_level = rst_level_ff;
    if (rst_sync_ff[1] == rst_sync_ff[2] && !cpu_reset_instr) begin
      nxt_rst_level = rst_sync_ff[2];
    end
    nxt_sel = pad_sel_clkout;
    nxt_dis = ~clkout_enable;
    nxt_hi  = crystal_sel_high;
    nxt_clkgen = clkgen_ff ^ sys_en;
    nxt_pin_in = pin_in_ff;
    if (pad_sync_ff[1] == pad_sync_ff[2]) begin
      nxt_pin_in = pad_sync_ff[2];
    end
    if (sel_ff) begin
      nxt_pin_o  = clkgen_ff & ~dis_ff;
      nxt_pin_oe = ~dis_ff;
    end else begin
      nxt_pin_o  = port_f_bit_two_out;
      nxt_pin_oe = port_f_bit_two_oe;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff  <= clk_rst_pkg::SYNC_RST;
      pad_sync_ff  <= '0;
      rst_level_ff <= 1'b0;
      sel_ff       <= clk_rst_pkg::PAD_SEL_RST;
      dis_ff       <= ~clk_rst_pkg::CLKOUT_EN_RST;
      hi_ff        <= 1'b0;
      clkgen_ff    <= 1'b0;
      pin_o_ff     <= 1'b0;
      pin_oe_ff    <= 1'b0;
      pin_in_ff    <= 1'b0;
    end else begin
      rst_sync_ff  <= nxt_rst_sync;
      pad_sync_ff  <= nxt_pad_sync;
      rst_level_ff <= nxt_rst_level;
      sel_ff       <= nxt_sel;
      dis_ff       <= nxt_dis;
      hi_ff        <= nxt_hi;
      clkgen_ff    <= nxt_clkgen;
      pin_o_ff     <= nxt_pin_o;
      pin_oe_ff    <= nxt_pin_oe;
      pin_in_ff    <= nxt_pin_in;
    end
  end

  // Assertions
  property p_reset_follow;
    @(posedge sys_clk) disable iff (!rst_b)
    (rst_sync_ff[2] == 1'b0 && rst_sync_ff[1] == 1'b0 && !cpu_reset_instr) |=> !cpu_reset_b;
  endproperty
  a_reset_follow: assert property (p_reset_follow) else $error("reset pin low not applied");
  property p_instr_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    cpu_reset_instr |=> $stable(cpu_reset_b);
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("reset moved during reset instruction");
  property p_both_reset;
    @(posedge sys_clk) disable iff (!rst_b)
    (rst_sync_ff[2] == 1'b0 && rst_sync_ff[1] == 1'b0 && !cpu_reset_instr) |=> !periph_reset_b;
  endproperty
  a_both_reset: assert property (p_both_reset) else $error("cpu and peripheral reset differ");
  property p_disable;
    @(posedge sys_clk) disable iff (!rst_b)
    (!clkout_enable && pad_sel_clkout) ##1 (dis_ff && sel_ff) |=> !clock_output_pin_oe && !clock_output_pin_o;
  endproperty
  a_disable: assert property (p_disable) else $error("clock output not disabled");
  property p_gpio;
    @(posedge sys_clk) disable iff (!rst_b)
    !sel_ff |=> clock_output_pin_oe == $past(port_f_bit_two_oe) && clock_output_pin_o == $past(port_f_bit_two_out);
  endproperty
  a_gpio: assert property (p_gpio) else $error("pad not under port control");
  property p_clkout;
    @(posedge sys_clk) disable iff (!rst_b)
    (sel_ff && !dis_ff) |=> clock_output_pin_oe && clock_output_pin_o == $past(clkgen_ff);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock output wrong");
  property p_sys_rate;
    @(posedge sys_clk) disable iff (!rst_b)
    sys_en |=> !sys_en [*6];
  endproperty
  a_sys_rate: assert property (p_sys_rate) else $error("system clock enable too fast");
  property p_sys_period;
    @(posedge sys_clk) disable iff (!rst_b)
    sys_en |-> ##[1:7] sys_en;
  endproperty
  a_sys_period: assert property (p_sys_period) else $error("system clock enable late");
  property p_reset_pad;
    @(posedge sys_clk) $rose(rst_b) |-> !clock_output_pin_oe && !sel_ff;
  endproperty
  a_reset_pad: assert property (p_reset_pad) else $error("pad not input after reset");
  c_clkout: cover property (@(posedge sys_clk) disable iff (!rst_b) sel_ff && clock_output_pin_oe);
  c_instr: cover property (@(posedge sys_clk) disable iff (!rst_b) cpu_reset_instr && !rst_sync_ff[2]);
  c_reset: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(cpu_reset_b));
  property p_dma_rate;
    @(posedge sys_clk) disable iff (!rst_b)
    display_dma_clock |=> !display_dma_clock [*6];
  endproperty
  a_dma_rate: assert property (p_dma_rate) else $error("display DMA enable too fast");
  property p_dma_period;
    @(posedge sys_clk) disable iff (!rst_b)
    display_dma_clock |-> ##7 display_dma_clock;
  endproperty
  a_dma_period: assert property (p_dma_period) else $error("display DMA enable not periodic");
  property p_crystal_sel;
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> crystal_is_high == $past(crystal_sel_high);
  endproperty
  a_crystal_sel: assert property (p_crystal_sel) else $error("crystal select not registered");
  property p_reset_release;
    @(posedge sys_clk) disable iff (!rst_b)
    (rst_sync_ff[2] && rst_sync_ff[1] && !cpu_reset_instr) |=> cpu_reset_b;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset not released");
  property p_instr_periph;
    @(posedge sys_clk) disable iff (!rst_b)
    cpu_reset_instr |=> $stable(periph_reset_b);
  endproperty
  a_instr_periph: assert property (p_instr_periph) else $error("peripheral reset moved during instruction");
  property p_pad_filter;
    @(posedge sys_clk) disable iff (!rst_b)
    (pad_sync_ff[2] == pad_sync_ff[1]) |=> port_f_bit_two_in == $past(pad_sync_ff[2]);
  endproperty
  a_pad_filter: assert property (p_pad_filter) else $error("pad input not filtered");
  c_gpio_drive: cover property (@(posedge sys_clk) disable iff (!rst_b) !sel_ff && clock_output_pin_oe);
  c_clkout_off: cover property (@(posedge sys_clk) disable iff (!rst_b) sel_ff && dis_ff && !clock_output_pin_oe);
endmodule : clock_reset_pin_logic
`default_nettype wire

// File: hdl/prescaler.sv
// Parameterised enable-pulse prescaler
`timescale 1ns/100ps
`default_nettype none
module prescaler #(
  parameter int unsigned W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic         en_in,
  input  wire logic [W-1:0] last,
  output logic              en_out
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    en_out  = 1'b0;
    if (en_in) begin
      if (cnt_ff >= last) begin
        nxt_cnt = '0;
        en_out  = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : prescaler
`default_nettype wire

// File: testbench/ext_board.sv
// Crystal, reset source and pad load beside the block
`timescale 1ns/100ps
`default_nettype none
module ext_board #(
  parameter int HOLD         = 20,
  parameter int CRYSTAL_HALF = 5
) (
  input  wire logic sys_clk,
  input  wire logic rst_req,
  input  wire logic pad_o,
  input  wire logic pad_oe,
  input  wire logic ext_drv,
  output logic      crystal_input,
  output logic      reset_pin_b,
  output logic      pad_i
);
  int cnt = 0;
  initial begin
    crystal_input = 1'h0;
    reset_pin_b   = 1'h0;
  end
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    if (cnt % CRYSTAL_HALF == CRYSTAL_HALF - 1) crystal_input <= ~crystal_input;
    reset_pin_b <= (cnt >= HOLD) && !rst_req;
  end
  // Released pad follows the outside driver
  assign pad_i = pad_oe ? pad_o : ext_drv;
endmodule : ext_board
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the clock, reset and pad block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  logic sys_clk, rst_b, xsel, instr, psel, cen, pf_out, pf_oe, ext_drv, rst_req;
  logic xin, xout, pll, core, dma, rpin_b, cpu_b, per_b, pf_in, pad_i, pad_o, pad_oe, xhi, last;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  logic [31:0] lfsr = 32'h651004BE;
  clock_reset_pin_logic i_clock_reset_pin_logic (.sys_clk(sys_clk), .rst_b(rst_b), .crystal_input(xin),
    .crystal_sel_high(xsel), .crystal_drive_output(xout), .pll_output_clock(pll), .core_system_clock(core),
    .display_dma_clock(dma), .reset_pin_b(rpin_b), .cpu_reset_instr(instr), .cpu_reset_b(cpu_b),
    .periph_reset_b(per_b), .pad_sel_clkout(psel), .clkout_enable(cen), .port_f_bit_two_out(pf_out),
    .port_f_bit_two_oe(pf_oe), .port_f_bit_two_in(pf_in), .clock_output_pin_i(pad_i),
    .clock_output_pin_o(pad_o), .clock_output_pin_oe(pad_oe), .crystal_is_high(xhi));
  ext_board i_ext_board (.sys_clk(sys_clk), .rst_req(rst_req), .pad_o(pad_o), .pad_oe(pad_oe),
    .ext_drv(ext_drv), .crystal_input(xin), .reset_pin_b(rpin_b), .pad_i(pad_i));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Pad enable expected from the select, enable and port drive
  function automatic logic exp_oe(input logic sel, input logic en, input logic poe);
    return sel ? en : poe;
  endfunction : exp_oe
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Wait k edges, then settle to the falling edge
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc
  task automatic pad_case(input logic sel, input logic en);
    @(posedge sys_clk);
    psel <= sel;
    cen  <= en;
    cyc(4);
    `CHK(pad_oe, exp_oe(sel, en, pf_oe))
    if (!en) `CHK(pad_o, 1'h0)
  endtask : pad_case
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {rst_b, xsel, instr, psel, cen, pf_out, pf_oe, ext_drv, rst_req} = '0;
    cyc(10);
    @(posedge sys_clk);
    rst_b <= 1'h1;
    cyc(2);
    `CHK(pad_oe, 1'h0)
    cyc(20);
    `CHK(cpu_b, 1'h1)
    `CHK(per_b, 1'h1)
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      xsel <= i[0];
      cyc(2);
      `CHK(xhi, i[0])
      `CHK(xout, ~xin)
      `CHK(pll, 1'h1)
    end
    n = 0;
    for (int i = 0; i < 70; i++) begin
      cyc(0);
      n += int'(dma === 1'h1);
      `CHK(core, dma)
      @(posedge sys_clk);
    end
    `CHK(n, 10)
    repeat (20) begin
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      {pf_out, pf_oe, ext_drv} <= lfsr[2:0];
      cyc(5);
      `CHK(pad_oe, exp_oe(1'h0, 1'h0, pf_oe))
      if (pf_oe) `CHK(pad_o, pf_out)
      `CHK(pf_in, pad_i)
    end
    pad_case(1'h1, 1'h0);
    pad_case(1'h1, 1'h1);
    n = 0;
    last = pad_o;
    for (int i = 0; i < 14; i++) begin
      cyc(1);
      n += int'(pad_o !== last);
      last = pad_o;
    end
    `CHK(n, 2)
    pad_case(1'h0, 1'h1);
    @(posedge sys_clk);
    instr   <= 1'h1;
    rst_req <= 1'h1;
    cyc(6);
    `CHK(cpu_b, 1'h1)
    @(posedge sys_clk);
    rst_req <= 1'h0;
    cyc(6);
    @(posedge sys_clk);
    instr   <= 1'h0;
    rst_req <= 1'h1;
    cyc(6);
    `CHK(cpu_b, 1'h0)
    `CHK(per_b, 1'h0)
    @(posedge sys_clk);
    rst_req <= 1'h0;
    cyc(6);
    `CHK(cpu_b, 1'h1)
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
